/* logic/gpl_gpio.sv */
// top of the gpio block: registers, three ports and lcd bias control
//
// Contract
// R1 - direction bit 0 makes input, 1 makes push-pull output of data bit
// R2 - pull-up select acts only while the pin is an input
// R3 - input pull-up select 0 is high impedance, 1 enables pull-up
// R4 - reading data register of output pins returns stored data, not pad
// R5 - drive register bits 7:6 and 5:4 set port 2 nibble levels
// R6 - drive register bits 3:2 and 1:0 set port 0 nibble levels
// R7 - port 0 pins 0..4 have half-supply enables in bits 4:0
// R8 - enable 0 means ordinary io; enable 1 with data 1 gives half supply
// R9 - divider field bits 3:2 selects off, 12.5k, 37.5k or 87.5k
// R10 - implemented pins fixed; data, direction, pull-up reset to zero
// R11 - software sets unused pins as push-pull outputs
// R12 - unimplemented bits ignore writes, read zero, affect no pin
module gpl_gpio
    import gpl_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    input wire logic [7:0] p0_pad_i,
    input wire logic [7:0] p1_pad_i,
    input wire logic [7:0] p2_pad_i,
    output logic [7:0] p0_pad_o,
    output logic [7:0] p1_pad_o,
    output logic [7:0] p2_pad_o,
    output logic [7:0] p0_pad_oe_o,
    output logic [7:0] p1_pad_oe_o,
    output logic [7:0] p2_pad_oe_o,
    output logic [7:0] p0_pullup_o,
    output logic [7:0] p1_pullup_o,
    output logic [7:0] p2_pullup_o,
    output logic [4:0] p0_half_supply_o,
    output logic [3:0] lcd_divider_en_o,
    output gpl_level_t port0_lower_drive_level_o,
    output gpl_level_t port0_upper_drive_level_o,
    output gpl_level_t port2_lower_drive_level_o,
    output gpl_level_t port2_upper_drive_level_o
);
    `include "gpl_regs.svh"

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        gpl_port_t p0;
        gpl_port_t p1;
        gpl_port_t p2;
        logic [7:0] drive;
        logic [7:0] half;
        logic [7:0] div;
        logic [7:0] rdata;
    } gpl_state_t;

    gpl_state_t s_q;
    gpl_state_t s_d;

    logic [7:0] p0_read;
    logic [7:0] p1_read;
    logic [7:0] p2_read;
    logic [7:0] p0_half_all;
    logic [7:0] unused_p1_half;
    logic [7:0] unused_p2_half;

    // masks every stored byte so absent bits never hold a one
    function automatic logic [7:0] gpl_mask(input logic [7:0] addr);
        unique case (addr)
            `GPL_ADDR_P0_DATA, `GPL_ADDR_P0_DIR, `GPL_ADDR_P0_PU: gpl_mask = `GPL_P0_MASK;
            `GPL_ADDR_P1_DATA, `GPL_ADDR_P1_DIR, `GPL_ADDR_P1_PU: gpl_mask = `GPL_P1_MASK;
            `GPL_ADDR_P2_DATA, `GPL_ADDR_P2_DIR, `GPL_ADDR_P2_PU: gpl_mask = `GPL_P2_MASK;
            `GPL_ADDR_P0_HALF: gpl_mask = `GPL_HALF_MASK;
            `GPL_ADDR_LCD_DIV: gpl_mask = `GPL_DIV_MASK;
            `GPL_ADDR_DRIVE: gpl_mask = `GPL_DRIVE_MASK;
            default: gpl_mask = 8'h00;
        endcase
    endfunction

    // ------------------------------------------------------------
    // register writes and read mux
    // ------------------------------------------------------------
    always_comb begin
        logic [7:0] wv;
        wv = wdata_i & gpl_mask(addr_i); // see R12
        s_d = s_q;
        if (wr_i) begin
            unique case (addr_i)
                `GPL_ADDR_P0_DATA: s_d.p0.data = wv;
                `GPL_ADDR_P0_DIR: s_d.p0.dir = wv; // see R1
                `GPL_ADDR_P0_PU: s_d.p0.pu = wv;
                `GPL_ADDR_P1_DATA: s_d.p1.data = wv;
                `GPL_ADDR_P1_DIR: s_d.p1.dir = wv;
                `GPL_ADDR_P1_PU: s_d.p1.pu = wv;
                `GPL_ADDR_P2_DATA: s_d.p2.data = wv;
                `GPL_ADDR_P2_DIR: s_d.p2.dir = wv;
                `GPL_ADDR_P2_PU: s_d.p2.pu = wv;
                `GPL_ADDR_DRIVE: s_d.drive = wv; // see R5 see R6
                `GPL_ADDR_P0_HALF: s_d.half = wv; // see R7
                `GPL_ADDR_LCD_DIV: s_d.div = wv; // see R9
                default: s_d = s_q;
            endcase
        end
        // data stands only in the cycle after the read strobe
        s_d.rdata = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `GPL_ADDR_P0_DATA: s_d.rdata = p0_read; // see R4
                `GPL_ADDR_P0_DIR: s_d.rdata = s_q.p0.dir;
                `GPL_ADDR_P0_PU: s_d.rdata = s_q.p0.pu;
                `GPL_ADDR_P1_DATA: s_d.rdata = p1_read;
                `GPL_ADDR_P1_DIR: s_d.rdata = s_q.p1.dir;
                `GPL_ADDR_P1_PU: s_d.rdata = s_q.p1.pu;
                `GPL_ADDR_P2_DATA: s_d.rdata = p2_read;
                `GPL_ADDR_P2_DIR: s_d.rdata = s_q.p2.dir;
                `GPL_ADDR_P2_PU: s_d.rdata = s_q.p2.pu;
                `GPL_ADDR_DRIVE: s_d.rdata = s_q.drive;
                `GPL_ADDR_P0_HALF: s_d.rdata = s_q.half;
                `GPL_ADDR_LCD_DIV: s_d.rdata = s_q.div;
                default: s_d.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0; // see R10
        end else begin
            s_q <= s_d;
        end
    end

    // ------------------------------------------------------------
    // ports
    // ------------------------------------------------------------
    // implemented pin sets: see R10
    gpl_pin_port #(.IMPL(`GPL_P0_MASK)) u_port0 (
        .data_i(s_q.p0.data),
        .dir_i(s_q.p0.dir),
        .pu_i(s_q.p0.pu),
        .half_i(s_q.half),
        .pad_i(p0_pad_i),
        .pad_o(p0_pad_o),
        .pad_oe_o(p0_pad_oe_o),
        .pullup_o(p0_pullup_o),
        .half_o(p0_half_all),
        .read_o(p0_read)
    );

    gpl_pin_port #(.IMPL(`GPL_P1_MASK)) u_port1 (
        .data_i(s_q.p1.data),
        .dir_i(s_q.p1.dir),
        .pu_i(s_q.p1.pu),
        .half_i(8'h00),
        .pad_i(p1_pad_i),
        .pad_o(p1_pad_o),
        .pad_oe_o(p1_pad_oe_o),
        .pullup_o(p1_pullup_o),
        .half_o(unused_p1_half),
        .read_o(p1_read)
    );

    gpl_pin_port #(.IMPL(`GPL_P2_MASK)) u_port2 (
        .data_i(s_q.p2.data),
        .dir_i(s_q.p2.dir),
        .pu_i(s_q.p2.pu),
        .half_i(8'h00),
        .pad_i(p2_pad_i),
        .pad_o(p2_pad_o),
        .pad_oe_o(p2_pad_oe_o),
        .pullup_o(p2_pullup_o),
        .half_o(unused_p2_half),
        .read_o(p2_read)
    );

    // ------------------------------------------------------------
    // lcd bias and drive levels
    // ------------------------------------------------------------
    assign p0_half_supply_o = p0_half_all[4:0]; // see R7 see R8

    gpl_lcd_bias u_bias (
        .div_sel_i(s_q.div[`GPL_DIV_LSB +: 2]),
        .half_i(p0_half_all[4:0]),
        .div_en_o(lcd_divider_en_o)
    );

    // code 00 strongest, 11 weakest
    assign port2_upper_drive_level_o = s_q.drive[`GPL_P2_UP_LSB +: 2]; // see R5
    assign port2_lower_drive_level_o = s_q.drive[`GPL_P2_LO_LSB +: 2]; // see R5
    assign port0_upper_drive_level_o = s_q.drive[`GPL_P0_UP_LSB +: 2]; // see R6
    assign port0_lower_drive_level_o = s_q.drive[`GPL_P0_LO_LSB +: 2]; // see R6

    assign rdata_o = s_q.rdata;
endmodule // gpl_gpio

/* shared/gpl_regs.svh */
// register offsets, field positions, masks and reset values of the gpio block
`ifndef GPL_REGS_SVH
`define GPL_REGS_SVH

`define GPL_ADDR_P0_DATA 8'h80
`define GPL_ADDR_LCD_DIV 8'h8f
`define GPL_ADDR_P1_DATA 8'h90
`define GPL_ADDR_P1_DIR 8'h91
`define GPL_ADDR_DRIVE 8'h97
`define GPL_ADDR_P0_DIR 8'h9a
`define GPL_ADDR_P0_PU 8'h9b
`define GPL_ADDR_P0_HALF 8'h9c
`define GPL_ADDR_P2_DATA 8'ha0
`define GPL_ADDR_P2_DIR 8'ha1
`define GPL_ADDR_P2_PU 8'ha2
`define GPL_ADDR_P1_PU 8'h92

`define GPL_P0_MASK 8'h3f
`define GPL_P1_MASK 8'hcf
`define GPL_P2_MASK 8'hf3
`define GPL_HALF_MASK 8'h1f
`define GPL_DIV_MASK 8'h0c
`define GPL_DRIVE_MASK 8'hff

`define GPL_P2_UP_LSB 6
`define GPL_P2_LO_LSB 4
`define GPL_P0_UP_LSB 2
`define GPL_P0_LO_LSB 0
`define GPL_DIV_LSB 2

`define GPL_RESET_VALUE 8'h00

`endif

/* shared/gpl_pkg.sv */
// types shared by the gpio block
package gpl_pkg;
    typedef logic [1:0] gpl_level_t;
    typedef enum logic [1:0] {
        GPL_DIV_OFF,
        GPL_DIV_12K5,
        GPL_DIV_37K5,
        GPL_DIV_87K5
    } gpl_div_t;
    typedef struct packed {
        logic [7:0] data;
        logic [7:0] dir;
        logic [7:0] pu;
    } gpl_port_t;
endpackage

/* logic/gpl_pin_port.sv */
// one 8-bit port: pad control and read-back
module gpl_pin_port
    import gpl_pkg::*;
#(
    parameter logic [7:0] IMPL = 8'hff
) (
    input wire logic [7:0] data_i,
    input wire logic [7:0] dir_i,
    input wire logic [7:0] pu_i,
    input wire logic [7:0] half_i,
    input wire logic [7:0] pad_i,
    output logic [7:0] pad_o,
    output logic [7:0] pad_oe_o,
    output logic [7:0] pullup_o,
    output logic [7:0] half_o,
    output logic [7:0] read_o
);
    genvar k;
    generate
        for (k = 0; k < 8; k++) begin : g_pin
            if (IMPL[k]) begin : g_on
                // half-supply level takes over the pad only with data high
                assign half_o[k] = half_i[k] & data_i[k]; // see R8
                assign pad_oe_o[k] = dir_i[k] & ~half_o[k]; // see R1
                assign pad_o[k] = data_i[k]; // see R1
                assign pullup_o[k] = ~dir_i[k] & pu_i[k] & ~half_o[k]; // see R2 see R3
                assign read_o[k] = dir_i[k] ? data_i[k] : pad_i[k]; // see R4
            end else begin : g_off
                // absent pin: inert whatever software wrote
                assign half_o[k] = 1'b0; // see R12
                assign pad_oe_o[k] = 1'b0;
                assign pad_o[k] = 1'b0;
                assign pullup_o[k] = 1'b0;
                assign read_o[k] = 1'b0;
            end
        end
    endgenerate
endmodule // gpl_pin_port

/* logic/gpl_lcd_bias.sv */
// lcd half-supply divider control
module gpl_lcd_bias
    import gpl_pkg::*;
(
    input wire logic [1:0] div_sel_i,
    input wire logic [4:0] half_i,
    output logic [3:0] div_en_o
);
    gpl_div_t sel;
    always_comb begin
        sel = gpl_div_t'(div_sel_i);
        div_en_o = 4'h0;
        unique case (sel) // see R9
            GPL_DIV_OFF: div_en_o = 4'h0;
            GPL_DIV_12K5: div_en_o = {3'h0, |half_i};
            GPL_DIV_37K5: div_en_o = {2'h0, |half_i, 1'b0};
            // top enable bit has no divider behind it and stays low
            GPL_DIV_87K5: div_en_o = {1'b0, |half_i, 2'h0};
        endcase
    end
endmodule // gpl_lcd_bias

/* dv/gpl_pad_model.sv */
// pad model: outside driver, pull-up and push-pull fight on one port
module gpl_pad_model (
    input wire logic clk_i,
    input wire logic [7:0] pad_o_i,
    input wire logic [7:0] oe_i,
    input wire logic [7:0] pullup_i,
    input wire logic [7:0] ext_i,
    input wire logic [7:0] ext_en_i,
    input wire logic clash_i,
    output logic [7:0] pad_i_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] float_q = 8'h00;
    // a floating pin toggles, so a stale level never passes as valid
    always_ff @(posedge clk_i) float_q <= ~float_q;
    always_comb begin
        for (int k = 0; k < 8; k++) begin
            if (oe_i[k]) pad_i_o[k] = pad_o_i[k] ^ clash_i;
            else if (ext_en_i[k]) pad_i_o[k] = ext_i[k];
            else if (pullup_i[k]) pad_i_o[k] = 1'b1;
            else pad_i_o[k] = float_q[k];
        end
    end
endmodule // gpl_pad_model

/* dv/gpl_gpio_properties.sv */
// port checks for the gpio block
module gpl_gpio_properties (
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [7:0] p0_pad_o,
    input wire logic [7:0] p1_pad_o,
    input wire logic [7:0] p0_pad_oe_o,
    input wire logic [7:0] p1_pad_oe_o,
    input wire logic [7:0] p2_pad_oe_o,
    input wire logic [7:0] p0_pullup_o,
    input wire logic [7:0] p2_pullup_o,
    input wire logic [4:0] p0_half_supply_o,
    input wire logic [3:0] lcd_divider_en_o,
    input wire gpl_pkg::gpl_level_t port0_lower_drive_level_o,
    input wire gpl_pkg::gpl_level_t port0_upper_drive_level_o,
    input wire gpl_pkg::gpl_level_t port2_lower_drive_level_o,
    input wire gpl_pkg::gpl_level_t port2_upper_drive_level_o
);
    timeunit 1ns;
    timeprecision 1ps;
    import gpl_pkg::*;
    wire logic [7:0] lvl_w = {port2_upper_drive_level_o, port2_lower_drive_level_o,
        port0_upper_drive_level_o, port0_lower_drive_level_o};
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);
    sequence s_drive_wr;
        wr_i && addr_i == 8'h97;
    endsequence
    sequence s_p1_rd;
        rd_i && addr_i == 8'h90;
    endsequence
    a_drive_fields:
        assert property (s_drive_wr |=> lvl_w == $past(wdata_i)) else $error("drive levels");
    a_p1_dir_write:
        assert property (wr_i && addr_i == 8'h91 |=> p1_pad_oe_o == ($past(wdata_i) & 8'hcf))
        else $error("p1 direction");
    a_p1_read_out:
        assert property (s_p1_rd |=> ((rdata_o ^ $past(p1_pad_o)) & $past(p1_pad_oe_o)) == 8'h00)
        else $error("p1 output read");
    a_unmapped_read:
        assert property (rd_i && addr_i == 8'h93 |=> rdata_o == 8'h00) else $error("unmapped");
    a_pullup_out_excl:
        assert property (((p2_pad_oe_o & p2_pullup_o) | (p0_pad_oe_o & p0_pullup_o)) == 8'h00)
        else $error("pullup on output");
    a_absent_quiet:
        assert property (((p0_pad_oe_o | p0_pullup_o | p0_pad_o) & 8'hc0) == 8'h00
            && (p2_pad_oe_o & 8'h0c) == 8'h00) else $error("absent pin active");
    a_half_needs_data:
        assert property ((p0_half_supply_o & ~(p0_pad_o[4:0] & ~p0_pad_oe_o[4:0])) == 5'h00)
        else $error("half supply");
    a_div_onehot:
        assert property ($onehot0(lcd_divider_en_o) && !lcd_divider_en_o[3]
            && (lcd_divider_en_o == 4'h0 || p0_half_supply_o != 5'h00)) else $error("divider");
endmodule // gpl_gpio_properties
bind gpl_gpio gpl_gpio_properties u_props (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i,
    .rd_i, .rdata_o, .p0_pad_o, .p1_pad_o, .p0_pad_oe_o, .p1_pad_oe_o, .p2_pad_oe_o,
    .p0_pullup_o, .p2_pullup_o, .p0_half_supply_o, .lcd_divider_en_o,
    .port0_lower_drive_level_o, .port0_upper_drive_level_o, .port2_lower_drive_level_o,
    .port2_upper_drive_level_o);

/* dv/testbench.sv */
// self-checking bench for the gpio block
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import gpl_pkg::*;
    localparam logic [7:0] ADR [12] = '{8'h8f, 8'h91, 8'h97, 8'h9a, 8'h9b, 8'ha1, 8'ha2,
        8'h92, 8'h80, 8'h90, 8'ha0, 8'h9c};
    localparam logic [7:0] MSK [12] = '{8'h0c, 8'hcf, 8'hff, 8'h3f, 8'h3f, 8'hf3, 8'hf3,
        8'hcf, 8'h3f, 8'hcf, 8'hf3, 8'h1f};
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic clash = 1'b0;
    logic [7:0] ext = 8'h00;
    logic [7:0] ext_en = 8'hff;
    logic [7:0] e;
    wire logic [7:0] rdata_o;
    wire logic [7:0] pad_i [3];
    wire logic [7:0] pad_o [3];
    wire logic [7:0] oe [3];
    wire logic [7:0] pu [3];
    wire logic [4:0] half;
    wire logic [3:0] div_en;
    wire gpl_level_t lv [4];
    int num_errors = 0;
    int n_compared = 0;
    gpl_gpio DUT (.clk_i, .reset_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .p0_pad_i(pad_i[0]), .p1_pad_i(pad_i[1]), .p2_pad_i(pad_i[2]),
        .p0_pad_o(pad_o[0]), .p1_pad_o(pad_o[1]), .p2_pad_o(pad_o[2]),
        .p0_pad_oe_o(oe[0]), .p1_pad_oe_o(oe[1]), .p2_pad_oe_o(oe[2]),
        .p0_pullup_o(pu[0]), .p1_pullup_o(pu[1]), .p2_pullup_o(pu[2]),
        .p0_half_supply_o(half), .lcd_divider_en_o(div_en),
        .port0_lower_drive_level_o(lv[0]), .port0_upper_drive_level_o(lv[1]),
        .port2_lower_drive_level_o(lv[2]), .port2_upper_drive_level_o(lv[3]));
    for (genvar g = 0; g < 3; g++) begin : g_pads
        gpl_pad_model u_pad (.clk_i, .pad_o_i(pad_o[g]), .oe_i(oe[g]), .pullup_i(pu[g]),
            .ext_i(ext), .ext_en_i(ext_en), .clash_i(clash), .pad_i_o(pad_i[g]));
    end
    initial forever #12.5 clk_i = ~clk_i;
    task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, exp, seen);
        end
    endtask
    // strobes drop and one idle edge passes, so no signal is set twice in a step
    task automatic wr(logic [7:0] a, logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
        @(posedge clk_i);
    endtask
    task automatic rd(logic [7:0] a, logic [7:0] exp);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 chk("rdata", rdata_o, exp);
        @(posedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        #50000;
        num_errors++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (ADR[i]) rd(ADR[i], 8'h00);
        $display("test reset values done");
        // pads fight the drivers, so reads must come from the data registers
        clash <= 1'b1;
        foreach (ADR[i]) begin
            wr(ADR[i], 8'hff);
            rd(ADR[i], MSK[i]);
        end
        wr(8'h93, 8'hff);
        rd(8'h93, 8'h00);
        chk("p1 oe", oe[1], 8'hcf);
        chk("p1 pad", pad_o[1], 8'hcf);
        chk("p1 pu", pu[1], 8'h00);
        chk("p0 pu", pu[0], 8'h00);
        chk("p0 pad", pad_o[0], 8'h3f);
        chk("p2 pad", pad_o[2], 8'hf3);
        chk("p2 oe", oe[2], 8'hf3);
        chk("p0 oe", oe[0], 8'h20);
        chk("div", {4'h0, div_en}, 8'h04);
        $display("test write all done");
        for (int k = 0; k < 4; k++) begin
            e = {2'(k), 2'(k + 1), 2'(k + 2), 2'(k + 3)};
            wr(8'h97, e);
            chk("levels", {lv[3], lv[2], lv[1], lv[0]}, e);
        end
        $display("test drive levels done");
        wr(8'h9c, 8'h15);
        for (int k = 0; k < 4; k++) begin
            wr(8'h8f, 8'(k << 2));
            chk("div", {4'h0, div_en}, k == 0 ? 8'h00 : 8'(1 << (k - 1)));
        end
        chk("half", {3'h0, half}, 8'h15);
        chk("p0 oe", oe[0], 8'h2a);
        wr(8'h80, 8'h00);
        chk("half", {3'h0, half}, 8'h00);
        chk("p0 oe", oe[0], 8'h3f);
        chk("div", {4'h0, div_en}, 8'h00);
        $display("test half supply done");
        clash <= 1'b0;
        wr(8'ha1, 8'h00);
        wr(8'ha2, 8'hff);
        ext_en <= 8'h00;
        chk("p2 pu", pu[2], 8'hf3);
        chk("p2 oe", oe[2], 8'h00);
        rd(8'ha0, 8'hf3);
        wr(8'ha2, 8'h00);
        ext <= 8'ha5;
        ext_en <= 8'hff;
        chk("p2 pu", pu[2], 8'h00);
        rd(8'ha0, 8'ha1);
        wr(8'ha2, 8'hff);
        wr(8'ha1, 8'hff);
        chk("p2 pu", pu[2], 8'h00);
        wr(8'h91, 8'h00);
        chk("p1 pu", pu[1], 8'hcf);
        wr(8'h9a, 8'h00);
        chk("p0 pu", pu[0], 8'h3f);
        // half supply on an input pin takes the pull-up away
        wr(8'h80, 8'h3f);
        chk("p0 pu", pu[0], 8'h2a);
        chk("half", {3'h0, half}, 8'h15);
        $display("test pull-up done");
        // reset in mid-run must clear everything written so far
        ext <= 8'h00;
        reset_n_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        foreach (ADR[i]) rd(ADR[i], 8'h00);
        chk("div", {4'h0, div_en}, 8'h00);
        chk("p0 oe", oe[0], 8'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule // testbench
